//--- hw/lsa_pkg.sv
// package: constants, opcodes and types of the load/store and integer datapath
package lsa_pkg;
    localparam int          XLEN       = 32;
    localparam int          IMM_W      = 16;
    localparam int          RF_N       = 32;
    localparam int          IE_POS     = 0;
    localparam int          BYPASS_POS = 31;
    localparam logic [4:0]  ZERO_IDX   = 5'h00;
    localparam logic [31:0] ZERO_VAL   = 32'h0000_0000;
    localparam logic [31:0] STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] RESET_ADDR_DEF = 32'h0000_0000;

    typedef enum logic [5:0] {
        OP_AND, OP_OR, OP_XOR, OP_NOR, OP_ANDI, OP_ORI, OP_XORI,
        OP_ANDHI, OP_ORHI, OP_XORHI, OP_ADD, OP_SUB, OP_MUL, OP_DIV,
        OP_DIVU, OP_ADDI, OP_SUBI, OP_MULI, OP_MULXSS, OP_MULXUU,
        OP_MOV, OP_MOVI, OP_MOVUI, OP_MOVHI,
        OP_CMPEQ, OP_CMPNE, OP_CMPGE, OP_CMPGEU, OP_CMPGT, OP_CMPGTU,
        OP_CMPLE, OP_CMPLEU, OP_CMPLT, OP_CMPLTU,
        OP_CMPEQI, OP_CMPNEI, OP_CMPGEI, OP_CMPGEUI, OP_CMPGTI, OP_CMPGTUI,
        OP_CMPLEI, OP_CMPLEUI, OP_CMPLTI, OP_CMPLTUI,
        OP_LDB, OP_LDBU, OP_LDH, OP_LDHU, OP_LDW,
        OP_LDBIO, OP_LDBUIO, OP_LDHIO, OP_LDHUIO, OP_LDWIO,
        OP_STB, OP_STH, OP_STW, OP_STBIO, OP_STHIO, OP_STWIO,
        OP_CACHE, OP_WRSTAT, OP_RDSTAT
    } lsa_op_e;

    typedef enum logic [1:0] {SZ_B, SZ_H, SZ_W} lsa_sz_e;
    typedef enum logic [2:0] {CMP_EQ, CMP_NE, CMP_GE, CMP_GT, CMP_LE, CMP_LT} lsa_cmp_e;
    typedef enum logic [1:0] {ST_INIT = 2'b00, ST_IDLE = 2'b01, ST_MEM = 2'b11} lsa_st_e;
endpackage

//--- hw/lsa_cmp.sv
// compare unit: one-bit relation of two 32-bit operands
`timescale 1ns/100ps
`default_nettype none
module lsa_cmp
    import lsa_pkg::*;
(
    input  wire logic [31:0] i_a,    // left operand
    input  wire logic [31:0] i_b,    // right operand
    input  wire lsa_cmp_e    i_kind, // relation
    input  wire logic        i_uns,  // unsigned relation
    output logic             o_true  // relation holds
);
    logic lt;
    logic eq;

    always_comb begin
        eq = (i_a == i_b);
        lt = i_uns ? (i_a < i_b) : ($signed(i_a) < $signed(i_b));
        unique case (i_kind)
            CMP_EQ: o_true = eq;
            CMP_NE: o_true = !eq;
            CMP_GE: o_true = !lt;
            CMP_GT: o_true = !lt && !eq;
            CMP_LE: o_true = lt || eq;
            CMP_LT: o_true = lt;
            default: o_true = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

//--- hw/lsa_ld_align.sv
// load aligner: picks the addressed lane and extends it to a word
`timescale 1ns/100ps
`default_nettype none
module lsa_ld_align
    import lsa_pkg::*;
(
    input  wire logic [31:0] i_rdata, // word read from the bus
    input  wire logic [1:0]  i_lane,  // low address bits
    input  wire lsa_sz_e     i_size,  // access size
    input  wire logic        i_uns,   // zero-extend when high
    output logic      [31:0] o_data   // extended result
);
    logic [31:0] sh;

    always_comb begin
        // halves ignore the low lane bit, matching their byte enables
        sh = i_rdata >> {i_lane[1], i_lane[0] & (i_size == SZ_B), 3'b000};
        unique case (i_size)
            SZ_B:    o_data = {{24{sh[7] & !i_uns}}, sh[7:0]};
            SZ_H:    o_data = {{16{sh[15] & !i_uns}}, sh[15:0]};
            default: o_data = i_rdata;
        endcase
    end
endmodule
`default_nettype wire

//--- hw/lsa_core.sv
// load/store and integer execution datapath with register file and status
//
// Summary of operation
// - forms 32-bit byte addresses, one shared space
// - 32-bit data, byte, half and word accesses
// - little-endian: higher bytes at higher addresses
// - address is register plus sign-extended displacement
// - zero register always reads zero, even reset
// - top address bit selects uncached, 2 GB space
// - cache management operations complete as no-ops
// - reset clears status, invalidates reset line, fetches
// - reset address is a build-time parameter
// - other registers and caches need no reset
// - ordinary accesses may be cached or buffered
// - io accesses uncached, in order, never dropped
// - signed loads sign-extend, unsigned zero-extend
// - register AND, OR, XOR, NOR
// - low-immediate logic zero-extends the immediate
// - high-immediate logic shifts immediate up sixteen
// - add, sub, mul, divides; signed immediate forms
// - high multiply, signed and unsigned variants
// - move immediate signed, low or high halves
// - compares write exactly one or zero
// - eq, ne and signed/unsigned relations
// - immediate compares extend by signedness
// - interrupts recognised only while enable bit set
`timescale 1ns/100ps
`default_nettype none
module lsa_core
    import lsa_pkg::*;
#(
    parameter logic [31:0] RESET_ADDR = RESET_ADDR_DEF, // fetch start
    parameter bit          BYPASS_B31 = 1'b1            // top-bit cache bypass
) (
    input  wire logic        i_clk,          // clock, 125 MHz
    input  wire logic        i_rst,          // async reset, active high
    input  wire logic        i_op_valid,     // operation offered
    output logic             o_op_ready,     // operation can be taken
    input  wire lsa_op_e     i_op,           // decoded operation
    input  wire logic [4:0]  i_dst,          // destination register
    input  wire logic [4:0]  i_src_a,        // first source register
    input  wire logic [4:0]  i_src_b,        // second source register
    input  wire logic [15:0] i_imm,          // 16-bit immediate
    output logic             o_done,         // operation finished, pulse
    output logic      [31:0] o_result,       // last result or load data
    output logic             o_mem_req,      // bus request, held to ack
    output logic             o_mem_we,       // store when high
    output logic      [31:0] o_mem_addr,     // byte address
    output logic      [3:0]  o_mem_be,       // byte lanes
    output logic      [31:0] o_mem_wdata,    // store data on lanes
    output logic             o_mem_uncached, // bypass cache and buffer
    input  wire logic        i_mem_ack,      // bus cycle complete
    input  wire logic [31:0] i_mem_rdata,    // read data
    output logic             o_icache_inval, // invalidate reset line
    output logic      [31:0] o_fetch_addr,   // reset fetch address
    output logic             o_fetch_start,  // begin fetching, pulse
    output logic             o_irq_en        // interrupt enable bit
);
    typedef struct packed {
        lsa_st_e          st;
        logic [31:0][31:0] rf;
        logic [31:0]      status;
        logic [31:0]      result;
        logic             done;
        logic             mem_req;
        logic             mem_we;
        logic             mem_unc;
        logic [31:0]      addr;
        logic [31:0]      wdata;
        logic [3:0]       be;
        lsa_sz_e          size;
        logic             uns;
        logic [4:0]       dst;
        logic             fetch_go;
    } lsa_state_s;

    lsa_state_s r;
    lsa_state_s n;

    logic [31:0] ra;
    logic [31:0] rb;
    logic [31:0] imm_s;
    logic [31:0] imm_z;
    logic [31:0] imm_h;
    logic [31:0] ea;
    logic [63:0] p_ss;
    logic [63:0] p_uu;
    logic [31:0] q_s;
    logic [31:0] q_u;
    logic [31:0] cmp_b;
    lsa_cmp_e    cmp_kind;
    logic        cmp_uns;
    logic        cmp_true;
    logic [31:0] ld_val;

    assign ra    = (i_src_a == ZERO_IDX) ? ZERO_VAL : r.rf[i_src_a];
    assign rb    = (i_src_b == ZERO_IDX) ? ZERO_VAL : r.rf[i_src_b];
    assign imm_s = {{16{i_imm[15]}}, i_imm};
    assign imm_z = {16'h0000, i_imm};
    assign imm_h = {i_imm, 16'h0000};
    assign ea    = ra + imm_s;
    assign p_ss  = 64'($signed(ra) * $signed(rb));
    assign p_uu  = 64'(ra) * 64'(rb);
    assign q_s   = (rb == ZERO_VAL) ? ZERO_VAL : 32'($signed(ra) / $signed(rb));
    assign q_u   = (rb == ZERO_VAL) ? ZERO_VAL : ra / rb;

    // compare operand and relation from the operation
    always_comb begin
        cmp_b    = rb;
        cmp_kind = CMP_EQ;
        cmp_uns  = 1'b0;
        unique case (i_op)
            OP_CMPNE, OP_CMPNEI:     cmp_kind = CMP_NE;
            OP_CMPGE, OP_CMPGEI:     cmp_kind = CMP_GE;
            OP_CMPGEU, OP_CMPGEUI: begin
                cmp_kind = CMP_GE;
                cmp_uns  = 1'b1;
            end
            OP_CMPGT, OP_CMPGTI:     cmp_kind = CMP_GT;
            OP_CMPGTU, OP_CMPGTUI: begin
                cmp_kind = CMP_GT;
                cmp_uns  = 1'b1;
            end
            OP_CMPLE, OP_CMPLEI:     cmp_kind = CMP_LE;
            OP_CMPLEU, OP_CMPLEUI: begin
                cmp_kind = CMP_LE;
                cmp_uns  = 1'b1;
            end
            OP_CMPLT, OP_CMPLTI:     cmp_kind = CMP_LT;
            OP_CMPLTU, OP_CMPLTUI: begin
                cmp_kind = CMP_LT;
                cmp_uns  = 1'b1;
            end
            default:                 cmp_kind = CMP_EQ;
        endcase
        if (i_op >= OP_CMPEQI && i_op <= OP_CMPLTUI) begin
            cmp_b = cmp_uns ? imm_z : imm_s;
        end
    end

    lsa_cmp u_cmp (
        .i_a    (ra),
        .i_b    (cmp_b),
        .i_kind (cmp_kind),
        .i_uns  (cmp_uns),
        .o_true (cmp_true)
    );

    lsa_ld_align u_ld (
        .i_rdata (i_mem_rdata),
        .i_lane  (r.addr[1:0]),
        .i_size  (r.size),
        .i_uns   (r.uns),
        .o_data  (ld_val)
    );

    always_comb begin
        logic [31:0] res;
        logic        wr;
        logic        mem;
        logic        io;
        res       = ZERO_VAL;
        wr        = 1'b1;
        mem       = 1'b0;
        io        = 1'b0;
        n         = r;
        n.done    = 1'b0;
        n.fetch_go = 1'b0;
        unique case (r.st)
            ST_INIT: begin
                n.st       = ST_IDLE;
                n.fetch_go = 1'b1;
            end
            ST_IDLE: if (i_op_valid) begin
                unique case (i_op)
                    OP_AND:    res = ra & rb;
                    OP_OR:     res = ra | rb;
                    OP_XOR:    res = ra ^ rb;
                    OP_NOR:    res = ~(ra | rb);
                    OP_ANDI:   res = ra & imm_z;
                    OP_ORI:    res = ra | imm_z;
                    OP_XORI:   res = ra ^ imm_z;
                    OP_ANDHI:  res = ra & imm_h;
                    OP_ORHI:   res = ra | imm_h;
                    OP_XORHI:  res = ra ^ imm_h;
                    OP_ADD:    res = ra + rb;
                    OP_SUB:    res = ra - rb;
                    OP_MUL:    res = p_uu[31:0];
                    OP_DIV:    res = q_s;
                    OP_DIVU:   res = q_u;
                    OP_ADDI:   res = ra + imm_s;
                    OP_SUBI:   res = ra - imm_s;
                    OP_MULI:   res = 32'(ra * imm_s);
                    OP_MULXSS: res = p_ss[63:32];
                    OP_MULXUU: res = p_uu[63:32];
                    OP_MOV:    res = ra;
                    OP_MOVI:   res = imm_s;
                    OP_MOVUI:  res = imm_z;
                    OP_MOVHI:  res = imm_h;
                    OP_LDB, OP_LDBU, OP_LDH, OP_LDHU, OP_LDW,
                    OP_STB, OP_STH, OP_STW: mem = 1'b1;
                    OP_LDBIO, OP_LDBUIO, OP_LDHIO, OP_LDHUIO, OP_LDWIO,
                    OP_STBIO, OP_STHIO, OP_STWIO: begin
                        mem = 1'b1;
                        io  = 1'b1;
                    end
                    OP_CACHE:  wr = 1'b0;
                    OP_WRSTAT: begin
                        wr       = 1'b0;
                        n.status = ra;
                    end
                    OP_RDSTAT: res = r.status;
                    default:   res = {31'h0000_0000, cmp_true};
                endcase
                if (mem) begin
                    n.st      = ST_MEM;
                    n.mem_req = 1'b1;
                    n.dst     = i_dst;
                    n.mem_we  = (i_op >= OP_STB);
                    n.addr    = ea;
                    n.mem_unc = io || (BYPASS_B31 && ea[BYPASS_POS]);
                    if (BYPASS_B31) begin
                        n.addr[BYPASS_POS] = 1'b0;
                    end
                    n.uns  = (i_op == OP_LDBU) || (i_op == OP_LDHU) ||
                             (i_op == OP_LDBUIO) || (i_op == OP_LDHUIO);
                    unique case (i_op)
                        OP_LDB, OP_LDBU, OP_STB, OP_LDBIO, OP_LDBUIO, OP_STBIO: begin
                            n.size  = SZ_B;
                            n.be    = 4'h1 << ea[1:0];
                            n.wdata = {4{rb[7:0]}};
                        end
                        OP_LDH, OP_LDHU, OP_STH, OP_LDHIO, OP_LDHUIO, OP_STHIO: begin
                            n.size  = SZ_H;
                            n.be    = ea[1] ? 4'hC : 4'h3;
                            n.wdata = {2{rb[15:0]}};
                        end
                        default: begin
                            n.size  = SZ_W;
                            n.be    = 4'hF;
                            n.wdata = rb;
                        end
                    endcase
                end else begin
                    n.done   = 1'b1;
                    n.result = res;
                    if (wr) begin
                        n.rf[i_dst] = res;
                    end
                end
            end
            ST_MEM: if (i_mem_ack) begin
                n.st      = ST_IDLE;
                n.mem_req = 1'b0;
                n.done    = 1'b1;
                if (!r.mem_we) begin
                    n.result    = ld_val;
                    n.rf[r.dst] = ld_val;
                end
            end
            default: n.st = ST_INIT;
        endcase
        n.rf[ZERO_IDX] = ZERO_VAL;
    end

    // reset clears the whole state, rf included; st then loads ST_INIT and status STATUS_RST
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r        <= '0;
            r.st     <= ST_INIT;
            r.status <= STATUS_RST;
        end else begin
            r <= n;
        end
    end

    assign o_op_ready     = (r.st == ST_IDLE);
    assign o_done         = r.done;
    assign o_result       = r.result;
    assign o_mem_req      = r.mem_req;
    assign o_mem_we       = r.mem_we;
    assign o_mem_addr     = r.addr;
    assign o_mem_be       = r.be;
    assign o_mem_wdata    = r.wdata;
    assign o_mem_uncached = r.mem_unc;
    assign o_icache_inval = (r.st == ST_INIT);
    assign o_fetch_addr   = RESET_ADDR;
    assign o_fetch_start  = r.fetch_go;
    assign o_irq_en       = r.status[IE_POS];

    logic acc;
    assign acc = i_op_valid && o_op_ready;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    zero_reg_a: assert property (r.rf[ZERO_IDX] == ZERO_VAL)
        else $error("zero register not zero");
    reset_seq_a: assert property (o_icache_inval |-> !o_irq_en ##1 o_fetch_start && o_op_ready)
        else $error("reset sequence wrong");
    io_uncached_a: assert property (acc && i_op >= OP_LDBIO && i_op <= OP_LDWIO |=> o_mem_req && o_mem_uncached)
        else $error("io load not uncached");
    bypass_top_a: assert property (BYPASS_B31 && o_mem_req |-> !o_mem_addr[BYPASS_POS])
        else $error("address beyond 2 GB");
    req_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
        else $error("bus request dropped");
    ldb_sext_a: assert property (r.st == ST_MEM && i_mem_ack && !r.mem_we && r.size == SZ_B
        |=> o_done && o_result[31:8] == (r.uns ? 24'h000000 : {24{o_result[7]}}))
        else $error("byte load extension wrong");
    cmp_bool_a: assert property (acc && i_op >= OP_CMPEQ && i_op <= OP_CMPLTUI |=> o_done && o_result[31:1] == 31'h0)
        else $error("compare result not boolean");
    movhi_half_a: assert property (acc && i_op == OP_MOVHI |=> o_result == {$past(i_imm), 16'h0000})
        else $error("movhi result wrong");
    andi_zext_a: assert property (acc && i_op == OP_ANDI |=> o_result[31:16] == 16'h0000)
        else $error("andi immediate not zero-extended");
    add_sum_a: assert property (acc && i_op == OP_ADD |=> o_result == $past(ra) + $past(rb))
        else $error("add result wrong");

    load_done_c: cover property (r.st == ST_MEM && !r.mem_we ##1 o_done);
    store_done_c: cover property (r.st == ST_MEM && r.mem_we ##1 o_done);
    cmp_true_c: cover property (acc && i_op == OP_CMPGEU ##1 o_result == 32'h0000_0001);
endmodule
`default_nettype wire

//--- sim/lsa_mem_model.sv
// memory model: shared address space answering the datapath's bus cycles
`timescale 1ns/100ps
`default_nettype none
module lsa_mem_model (
    input  wire logic        i_clk,   // clock
    input  wire logic        i_rst,   // async reset, active high
    input  wire logic        i_req,   // bus request
    input  wire logic        i_we,    // store when high
    input  wire logic [31:0] i_addr,  // byte address
    input  wire logic [3:0]  i_be,    // byte lanes
    input  wire logic [31:0] i_wdata, // store data
    input  wire logic [3:0]  i_delay, // wait cycles before ack
    output logic             o_ack,   // cycle complete, one cycle
    output logic      [31:0] o_rdata, // read word
    output logic      [7:0]  o_count  // completed cycles
);
    logic [31:0] mem_r [64];
    logic [3:0]  wait_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_r  <= 4'h0;
            o_ack   <= 1'b0;
            o_rdata <= 32'h0;
            o_count <= 8'h00;
        end else begin
            o_ack   <= 1'b0;
            // released data lines keep toggling so stale values never match
            o_rdata <= ~o_rdata;
            if (i_req && !o_ack) begin
                if (wait_r >= i_delay) begin
                    wait_r  <= 4'h0;
                    o_ack   <= 1'b1;
                    o_rdata <= mem_r[i_addr[7:2]];
                    o_count <= o_count + 8'h01;
                    for (int k = 0; k < 4; k++) begin
                        if (i_we && i_be[k]) begin
                            mem_r[i_addr[7:2]][8*k +: 8] <= i_wdata[8*k +: 8];
                        end
                    end
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/load_store_alu_datapath_tb.sv
// testbench: operation table, loads and stores, reset state of the datapath
`timescale 1ns/100ps
`default_nettype none
module load_store_alu_datapath_tb;
    import lsa_pkg::*;
    localparam logic [31:0] RST_PC = 32'h0000_0100;
    localparam logic [31:0] VA     = 32'hFFFF_FFF0;
    localparam logic [31:0] VB     = 32'h0000_0013;
    typedef struct {lsa_op_e op; logic [15:0] imm; logic [31:0] exp;} lsa_row_s;

    logic        i_clk      = 1'b0;
    logic        i_rst      = 1'b1;
    logic        i_op_valid = 1'b0;
    lsa_op_e     i_op       = OP_AND;
    logic [4:0]  i_dst      = 5'h00;
    logic [4:0]  i_src_a    = 5'h00;
    logic [4:0]  i_src_b    = 5'h00;
    logic [15:0] i_imm      = 16'h0000;
    logic [3:0]  delay      = 4'h0;
    logic        op_ready, done, mem_req, mem_we, mem_unc, mem_ack, inval, fstart, irq_en;
    logic [31:0] result, mem_addr, mem_wdata, mem_rdata, fetch_addr;
    logic [3:0]  mem_be;
    logic [7:0]  acc_cnt;
    logic [69:0] cap        = '0;
    int          mismatches = 0;
    int          checked    = 0;

    lsa_row_s alu_rows [44] = '{
        '{OP_AND, 16'h0, 32'h10}, '{OP_OR, 16'h0, 32'hFFFFFFF3}, '{OP_XOR, 16'h0, 32'hFFFFFFE3},
        '{OP_NOR, 16'h0, 32'hC}, '{OP_ANDI, 16'h8F0F, 32'h8F00}, '{OP_ORI, 16'h8F0F, 32'hFFFFFFFF},
        '{OP_XORI, 16'h8F0F, 32'hFFFF70FF}, '{OP_ANDHI, 16'h8F0F, 32'h8F0F0000},
        '{OP_ORHI, 16'h8F0F, 32'hFFFFFFF0}, '{OP_XORHI, 16'h8F0F, 32'h70F0FFF0},
        '{OP_ADD, 16'h0, 32'h3}, '{OP_SUB, 16'h0, 32'hFFFFFFDD}, '{OP_MUL, 16'h0, 32'hFFFFFED0},
        '{OP_DIV, 16'h0, 32'h0}, '{OP_DIVU, 16'h0, 32'h0D79435D}, '{OP_ADDI, 16'h8F0F, 32'hFFFF8EFF},
        '{OP_SUBI, 16'h8F0F, 32'h70E1}, '{OP_MULI, 16'h8F0F, 32'h70F10},
        '{OP_MULXSS, 16'h0, 32'hFFFFFFFF}, '{OP_MULXUU, 16'h0, 32'h12}, '{OP_MOV, 16'h0, 32'hFFFFFFF0},
        '{OP_MOVI, 16'h8F0F, 32'hFFFF8F0F}, '{OP_MOVUI, 16'h8F0F, 32'h8F0F},
        '{OP_MOVHI, 16'h8F0F, 32'h8F0F0000}, '{OP_CMPEQ, 16'h0, 32'h0}, '{OP_CMPNE, 16'h0, 32'h1},
        '{OP_CMPGE, 16'h0, 32'h0}, '{OP_CMPGEU, 16'h0, 32'h1}, '{OP_CMPGT, 16'h0, 32'h0},
        '{OP_CMPGTU, 16'h0, 32'h1}, '{OP_CMPLE, 16'h0, 32'h1}, '{OP_CMPLEU, 16'h0, 32'h0},
        '{OP_CMPLT, 16'h0, 32'h1}, '{OP_CMPLTU, 16'h0, 32'h0}, '{OP_CMPEQI, 16'hFFF0, 32'h1},
        '{OP_CMPNEI, 16'hFFF0, 32'h0}, '{OP_CMPGEI, 16'hFFF0, 32'h1}, '{OP_CMPGEUI, 16'hFFF0, 32'h1},
        '{OP_CMPGTI, 16'hFFF0, 32'h0}, '{OP_CMPGTUI, 16'hFFF0, 32'h1}, '{OP_CMPLEI, 16'hFFF0, 32'h1},
        '{OP_CMPLEUI, 16'hFFF0, 32'h0}, '{OP_CMPLTI, 16'hFFF0, 32'h0}, '{OP_CMPLTUI, 16'hFFF0, 32'h0}};
    lsa_row_s ld_rows [11] = '{
        '{OP_LDW, 16'hFFFC, 32'hFFFF13F0}, '{OP_LDB, 16'hFFFC, 32'hFFFFFFF0}, '{OP_LDBU, 16'hFFFC, 32'hF0},
        '{OP_LDB, 16'hFFFD, 32'h13}, '{OP_LDH, 16'hFFFE, 32'hFFFFFFFF}, '{OP_LDHU, 16'hFFFE, 32'hFFFF},
        '{OP_LDWIO, 16'hFFFC, 32'hFFFF13F0}, '{OP_LDBIO, 16'hFFFC, 32'hFFFFFFF0},
        '{OP_LDBUIO, 16'hFFFD, 32'h13}, '{OP_LDHIO, 16'hFFFC, 32'h13F0}, '{OP_LDHUIO, 16'hFFFE, 32'hFFFF}};

    lsa_core #(.RESET_ADDR(RST_PC), .BYPASS_B31(1'b1)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_op_valid(i_op_valid), .o_op_ready(op_ready), .i_op(i_op),
        .i_dst(i_dst), .i_src_a(i_src_a), .i_src_b(i_src_b), .i_imm(i_imm), .o_done(done),
        .o_result(result), .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr),
        .o_mem_be(mem_be), .o_mem_wdata(mem_wdata), .o_mem_uncached(mem_unc), .i_mem_ack(mem_ack),
        .i_mem_rdata(mem_rdata), .o_icache_inval(inval), .o_fetch_addr(fetch_addr),
        .o_fetch_start(fstart), .o_irq_en(irq_en));

    lsa_mem_model mem (
        .i_clk(i_clk), .i_rst(i_rst), .i_req(mem_req), .i_we(mem_we), .i_addr(mem_addr), .i_be(mem_be),
        .i_wdata(mem_wdata), .i_delay(delay), .o_ack(mem_ack), .o_rdata(mem_rdata), .o_count(acc_cnt));

    always #4 i_clk = ~i_clk;

    task automatic chk(input string n, input logic [69:0] s, input logic [69:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic rchk(input string n, input logic [31:0] e);
        chk(n, 70'(result), 70'(e));
    endtask

    task automatic do_op(input lsa_op_e op, input logic [4:0] d, input logic [4:0] a, input logic [4:0] b,
                         input logic [15:0] imm);
        int n;
        n = 0;
        while (op_ready !== 1'b1 && n < 50) begin
            @(negedge i_clk);
            n++;
        end
        i_op_valid = 1'b1;
        i_op = op;
        i_dst = d;
        i_src_a = a;
        i_src_b = b;
        i_imm = imm;
        @(negedge i_clk);
        i_op_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 50) begin
            if (mem_req === 1'b1) cap = {mem_we, mem_unc, mem_be, mem_addr, mem_wdata};
            @(negedge i_clk);
            n++;
        end
        if (n == 50) chk("done", 70'h0, 70'h1);
        // let an edge pass with valid low before the next request
        @(negedge i_clk);
    endtask

    task automatic set_reg(input logic [4:0] idx, input logic [31:0] v);
        do_op(OP_MOVHI, idx, 5'h00, 5'h00, v[31:16]);
        do_op(OP_ORI, idx, idx, 5'h00, v[15:0]);
    endtask

    task automatic do_reset;
        i_rst = 1'b1;
        repeat (5) @(negedge i_clk);
        chk("inval", 70'(inval), 70'h1);
        chk("irq_en", 70'(irq_en), 70'h0);
        chk("fetch_addr", 70'(fetch_addr), 70'(RST_PC));
        i_rst = 1'b0;
        @(negedge i_clk);
        chk("fetch_start", 70'({fstart, inval}), 70'h2);
        @(negedge i_clk);
        chk("fetch_end", 70'(fstart), 70'h0);
    endtask

    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        chk("watchdog", 70'h0, 70'h1);
        stop_test();
    end

    initial begin
        logic [7:0] c0;
        do_reset();
        set_reg(5'h01, VA);
        set_reg(5'h02, VB);
        foreach (alu_rows[k]) begin
            do_op(alu_rows[k].op, 5'h03, 5'h01, 5'h02, alu_rows[k].imm);
            rchk(alu_rows[k].op.name(), alu_rows[k].exp);
        end
        set_reg(5'h04, 32'h0000_0040);
        delay = 4'h3;
        do_op(OP_STW, 5'h03, 5'h04, 5'h01, 16'hFFFC);
        chk("stw", cap, {2'b10, 4'hF, 32'h3C, VA});
        delay = 4'h0;
        do_op(OP_STB, 5'h03, 5'h04, 5'h02, 16'hFFFD);
        chk("stb", cap, {2'b10, 4'h2, 32'h3D, 32'h1313_1313});
        foreach (ld_rows[k]) begin
            delay = 4'(k % 4);
            c0 = acc_cnt;
            do_op(ld_rows[k].op, 5'h03, 5'h04, 5'h00, ld_rows[k].imm);
            rchk(ld_rows[k].op.name(), ld_rows[k].exp);
            chk("ld_ctl", 70'(cap[69:68]), 70'(ld_rows[k].op >= OP_LDBIO));
            chk("ld_addr", 70'(cap[63:32]), 70'({30'hF, ld_rows[k].imm[1:0]}));
            chk("ld_count", 70'(acc_cnt), 70'(c0 + 8'h01));
        end
        do_op(OP_STHIO, 5'h03, 5'h04, 5'h01, 16'hFFFE);
        chk("sthio", cap, {2'b11, 4'hC, 32'h3E, 32'hFFF0_FFF0});
        do_op(OP_STBIO, 5'h03, 5'h04, 5'h02, 16'hFFFC);
        chk("stbio", cap, {2'b11, 4'h1, 32'h3C, 32'h1313_1313});
        set_reg(5'h05, 32'h8000_0040);
        do_op(OP_LDW, 5'h03, 5'h05, 5'h00, 16'hFFFC);
        rchk("bypass", 32'hFFF0_1313);
        chk("bypass_ctl", 70'(cap[69:32]), 70'({2'b01, 4'hF, 32'h3C}));
        do_op(OP_LDW, 5'h03, 5'h00, 5'h00, 16'h003C);
        chk("absolute", 70'(cap[69:32]), 70'({2'b00, 4'hF, 32'h3C}));
        do_op(OP_MOVI, 5'h00, 5'h00, 5'h00, 16'h1234);
        do_op(OP_MOV, 5'h03, 5'h00, 5'h00, 16'h0000);
        rchk("zero_reg", 32'h0);
        do_op(OP_MOVI, 5'h03, 5'h00, 5'h00, 16'h0055);
        do_op(OP_CACHE, 5'h03, 5'h01, 5'h02, 16'hFFFF);
        do_op(OP_MOV, 5'h07, 5'h03, 5'h00, 16'h0000);
        rchk("cache_nop", 32'h55);
        do_op(OP_MOVI, 5'h06, 5'h00, 5'h00, 16'h0001);
        do_op(OP_WRSTAT, 5'h00, 5'h06, 5'h00, 16'h0000);
        do_op(OP_RDSTAT, 5'h03, 5'h00, 5'h00, 16'h0000);
        rchk("status", 32'h1);
        chk("irq_on", 70'(irq_en), 70'h1);
        do_reset();
        do_op(OP_RDSTAT, 5'h03, 5'h00, 5'h00, 16'h0000);
        rchk("status_rst", 32'h0);
        do_op(OP_MOV, 5'h03, 5'h00, 5'h00, 16'h0000);
        rchk("zero_rst", 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
